// ==== lmb_consts.vh ====
// constants for the local muxed bus master
`ifndef LMB_CONSTS_VH
`define LMB_CONSTS_VH
`define LMB_CLK_DIV 2
`define LMB_ADDR_LSB 2
`define LMB_SIZE_W 2
`define LMB_DATA_W 32
`define LMB_RESET_PHASE 1'h0
`define LMB_RESET_STATE 3'h0
`endif

// ==== lmb_master.v ====
// multiplexed 32-bit local bus master with burst, wait states and bus lock
// Operation
// - internal processor clock is the double-rate bus clock divided by two
// - address phase drives word address on bits 2-31, burst count on 0-1
// - burst count 00..11 means one to four words
// - data phase carries 32-bit read or write data
// - bus lines float unless address or write data is driven
// - latch strobe low in address phase, off as data starts, floats in hold
// - address strobe asserted in address phase, removed in following data phase
// - burst reasserts address strobe in data phase after a ready cycle
// - write-not-read driven in address phase, held through data phases
// - direction low for reads and acknowledges, high for writes
// - direction never changes while transceiver enable is asserted
// - transceiver enable asserted through all data and wait phases
// - no ready extends data phase by a wait, no address strobe next
// - read-modify-write waits until shared lock line is free
// - lock asserted in read address phase, released in write address phase
// - lock asserted for the whole interrupt acknowledge
`include "lmb_consts.vh"
module lmb_master #(
	parameter DATA_W = `LMB_DATA_W
)(
	// clock and reset
	input wire bus_clock_2x,
	input wire reset_n,
	// user request side
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire req_rmw,
	input wire req_inta,
	input wire [29:0] req_word_addr,
	input wire [1:0] req_size,
	input wire [DATA_W-1:0] req_wdata,
	output wire wdata_take,
	output reg [DATA_W-1:0] rdata_q,
	output reg rdata_valid_q,
	output reg done_q,
	// bus side
	input wire [DATA_W-1:0] muxed_addr_data_bus_i,
	output reg [DATA_W-1:0] muxed_addr_data_bus_o,
	output reg muxed_addr_data_bus_oe,
	output reg addr_latch_n,
	output reg addr_latch_oe,
	output reg addr_strobe_n,
	output reg write_not_read,
	output reg xcvr_direction,
	output reg xcvr_enable_n,
	input wire ready_n,
	input wire hold_phase,
	input wire lock_n_i,
	output wire lock_n_o,
	output wire lock_n_oe
);
	// ----------------------------------------
	// state codes
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_LOCKW = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_WRADDR = 3'h4;
	localparam ST_WRDATA = 3'h5;

	// ----------------------------------------
	// clock divider
	// ----------------------------------------
	// core work happens only on the phase_q==1 edge, giving the halved processor clock
	reg phase_q;
	wire tick = phase_q;
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
			phase_q <= `LMB_RESET_PHASE;
		else
			phase_q <= ~phase_q;
	end

	// ----------------------------------------
	// transaction state
	// ----------------------------------------
	reg [2:0] state_q;
	reg [1:0] left_q;
	reg lock_q;
	reg rmw_q;
	reg inta_q;
	reg [29:0] addr_q;
	reg [1:0] size_q;

	assign req_ready = tick && (state_q == ST_IDLE) && !hold_phase;
	assign lock_n_o = 1'h0;
	assign lock_n_oe = lock_q;
	wire in_data = (state_q == ST_DATA) || (state_q == ST_WRDATA);
	wire ready = !ready_n;
	// write data is consumed when the agent signals ready in a write data phase
	assign wdata_take = tick && in_data && ready && write_not_read;

	function [DATA_W-1:0] addr_word;
		input [29:0] a;
		input [1:0] s;
		begin
			addr_word = {a, s};
		end
	endfunction

	function is_addr_state;
		input [2:0] s;
		begin
			is_addr_state = (s == ST_ADDR) || (s == ST_WRADDR);
		end
	endfunction

	function is_data_state;
		input [2:0] s;
		begin
			is_data_state = (s == ST_DATA) || (s == ST_WRDATA);
		end
	endfunction

	// ----------------------------------------
	// events shared by the output blocks
	// ----------------------------------------
	// each event already includes the processor tick
	wire addr_go = tick && is_addr_state(state_q);
	wire word_done = tick && is_data_state(state_q) && ready;
	wire last_word = word_done && (left_q == 2'h0);
	wire to_write = last_word && rmw_q && (state_q == ST_DATA);
	wire finish = last_word && !to_write;

	// ----------------------------------------
	// address strobe
	// ----------------------------------------
	// a word taken with more to come reopens the strobe for the next data phase,
	// while a wait state or the last word keeps it off
	reg addr_strobe_d;
	always @*
	begin
		addr_strobe_d = 1'h1;
		if (is_addr_state(state_q))
			addr_strobe_d = 1'h0;
		else if (is_data_state(state_q) && ready && (left_q != 2'h0))
			addr_strobe_d = 1'h0;
		else if (is_data_state(state_q) && !ready)
			addr_strobe_d = 1'h1;
	end

	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
			addr_strobe_n <= 1'h1;
		else if (tick)
			addr_strobe_n <= addr_strobe_d;
	end

	// ----------------------------------------
	// address latch strobe
	// ----------------------------------------
	// hold floats the latch strobe on any tick but blocks only new transactions; a request arriving in hold waits
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
		begin
			addr_latch_n <= 1'h1;
			addr_latch_oe <= 1'h1;
		end
		else if (tick)
		begin
			// low for exactly the address phase, so it goes high on the same tick edge that data starts
			addr_latch_n <= !is_addr_state(state_q);
			addr_latch_oe <= !hold_phase;
		end
	end

	// ----------------------------------------
	// burst word count
	// ----------------------------------------
	// reloaded in every address phase, so the write half of a locked pair starts afresh
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
			left_q <= 2'h0;
		else if (addr_go)
			left_q <= size_q;
		else if (word_done && (left_q != 2'h0))
			left_q <= left_q - 2'h1;
	end

	// ----------------------------------------
	// transceiver direction
	// ----------------------------------------
	// only reloaded in an address phase, where the enable is off, so it never moves under enable
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
			xcvr_direction <= 1'h0;
		else if (addr_go)
			xcvr_direction <= write_not_read;
	end

	// ----------------------------------------
	// bus lock
	// ----------------------------------------
	// open-drain line: only the enable moves, the pull-up brings it back high
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
			lock_q <= 1'h0;
		else if (addr_go)
			lock_q <= (state_q == ST_ADDR) && (rmw_q || inta_q);
		else if (finish)
			lock_q <= 1'h0;
	end

	// ----------------------------------------
	// read return and completion
	// ----------------------------------------
	// both pulses last one processor cycle
	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
		begin
			rdata_q <= {DATA_W{1'b0}};
			rdata_valid_q <= 1'h0;
			done_q <= 1'h0;
		end
		else if (tick)
		begin
			rdata_valid_q <= word_done && !write_not_read;
			done_q <= finish;
			if (word_done)
				rdata_q <= muxed_addr_data_bus_i;
		end
	end

	always @(posedge bus_clock_2x)
	begin
		if (!reset_n)
		begin
			state_q <= `LMB_RESET_STATE;
			rmw_q <= 1'h0;
			inta_q <= 1'h0;
			addr_q <= 30'h0;
			size_q <= 2'h0;
			muxed_addr_data_bus_o <= {DATA_W{1'b0}};
			muxed_addr_data_bus_oe <= 1'h0;
			write_not_read <= 1'h0;
			xcvr_enable_n <= 1'h1;
		end
		else
		begin
			if (tick)
			begin
				case (state_q)
					ST_IDLE:
					begin
						xcvr_enable_n <= 1'h1;
						muxed_addr_data_bus_oe <= 1'h0;
						if (req_valid && !hold_phase)
						begin
							rmw_q <= req_rmw;
							inta_q <= req_inta;
							addr_q <= req_word_addr;
							size_q <= req_rmw ? 2'h0 : req_size;
							write_not_read <= req_write && !req_rmw && !req_inta;
							state_q <= req_rmw ? ST_LOCKW : ST_ADDR;
						end
					end
					ST_LOCKW:
					begin
						if (lock_n_i)
							state_q <= ST_ADDR;
					end
					ST_ADDR, ST_WRADDR:
					begin
						muxed_addr_data_bus_o <= addr_word(addr_q, size_q);
						muxed_addr_data_bus_oe <= 1'h1;
						state_q <= (state_q == ST_ADDR) ? ST_DATA : ST_WRDATA;
					end
					ST_DATA, ST_WRDATA:
					begin
						xcvr_enable_n <= 1'h0;
						muxed_addr_data_bus_o <= req_wdata;
						muxed_addr_data_bus_oe <= write_not_read;
						if (ready && (left_q == 2'h0))
						begin
							xcvr_enable_n <= 1'h1;
							muxed_addr_data_bus_oe <= 1'h0;
							if (rmw_q && state_q == ST_DATA)
							begin
								write_not_read <= 1'h1;
								state_q <= ST_WRADDR;
							end
							else
								state_q <= ST_IDLE;
						end
					end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // lmb_master

// ==== lmb_monitor.sv ====
// checker for the local bus master
module lmb_monitor(
	// watched ports
	input wire bus_clock_2x,
	input wire reset_n,
	input wire done_q,
	input wire muxed_addr_data_bus_oe,
	input wire addr_latch_n,
	input wire addr_strobe_n,
	input wire write_not_read,
	input wire xcvr_direction,
	input wire xcvr_enable_n,
	input wire ready_n,
	input wire lock_n_i,
	input wire lock_n_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	wire de = !xcvr_enable_n;
	wire oe = muxed_addr_data_bus_oe;
	default clocking @(posedge bus_clock_2x); endclocking
	default disable iff (!reset_n);
	// two samples always span one tick edge
	sequence s_wt;
		de && ready_n ##1 de && ready_n;
	endsequence
	sequence s_al;
		!addr_latch_n [*2];
	endsequence
	a_wait_no_ads: assert property (s_wt |=> addr_strobe_n) else $error("ads");
	a_ale_short: assert property (s_al |=> addr_latch_n) else $error("ale");
	a_addr_drive: assert property (!addr_latch_n |-> !addr_strobe_n && oe && !de) else $error("addr");
	a_dir_hold: assert property (de && $past(de) |-> $stable(xcvr_direction)) else $error("dir");
	a_dir_kind: assert property (de |-> xcvr_direction == write_not_read) else $error("kind");
	a_data_oe: assert property (de |-> oe == write_not_read) else $error("oe");
	a_done_idle: assert property (done_q |-> addr_strobe_n && !de) else $error("idle");
	a_lock_free: assert property ($rose(lock_n_oe) |-> $past(lock_n_i)) else $error("lock");
endmodule // lmb_monitor
bind lmb_master lmb_monitor i_mon (.*);

// ==== lmb_agent.sv ====
// bus agent model with zero or one wait state per word
module lmb_agent(
	// bus ports
	input wire bus_clock_2x,
	input wire [31:0] muxed_addr_data_bus_o,
	input wire muxed_addr_data_bus_oe,
	input wire addr_latch_n,
	input wire xcvr_enable_n,
	input wire write_not_read,
	input wire slow,
	output wire [31:0] muxed_addr_data_bus_i,
	output wire ready_n,
	output logic [31:0] lat,
	output logic [31:0] last_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last = 0, rd;
	logic [1:0] c = 0;
	// ready spans two clocks; the word counts on the tick edge
	wire hit = !xcvr_enable_n && c == {slow, 1'b1};
	assign ready_n = !(!xcvr_enable_n && c >= {slow, 1'b0});
	// a released bus shows the inverse of its last value
	assign muxed_addr_data_bus_i = muxed_addr_data_bus_oe ? muxed_addr_data_bus_o :
		(!xcvr_enable_n && !write_not_read) ? rd : ~last;
	always @(posedge bus_clock_2x)
	begin
		last <= muxed_addr_data_bus_i;
		c <= (xcvr_enable_n || hit) ? 2'h0 : c + 2'h1;
		if (!addr_latch_n)
			lat <= muxed_addr_data_bus_o;
		rd <= !addr_latch_n ? {muxed_addr_data_bus_o[31:2], 2'h0} : hit ? rd + 32'h4 : rd;
		if (hit && write_not_read)
			last_w <= muxed_addr_data_bus_i;
	end
endmodule // lmb_agent

// ==== testbench.sv ====
// testbench for the local bus master
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic bus_clock_2x = 0, reset_n = 0, req_valid = 0, req_write, req_rmw, req_inta, hold_phase = 0, lk = 0, slow, seen;
	logic [29:0] req_word_addr;
	logic [1:0] req_size;
	logic [31:0] req_wdata = 32'hC3A55A3C;
	wire [31:0] muxed_addr_data_bus_i, muxed_addr_data_bus_o, rdata_q, lat, last_w;
	wire req_ready, wdata_take, rdata_valid_q, done_q, muxed_addr_data_bus_oe, addr_latch_n, addr_latch_oe;
	wire addr_strobe_n, write_not_read, xcvr_direction, xcvr_enable_n, ready_n, lock_n_o, lock_n_oe;
	// pulled-up lock line shared with another agent
	wire lock_n_i = !(lock_n_oe && !lock_n_o) && !lk;
	int errors = 0, total_checks = 0, n, ads_cnt, data_cnt;
	always #2 bus_clock_2x = ~bus_clock_2x;
	lmb_master i_dut (.*);
	lmb_agent i_agent (.*);
	task chk(input string s, input [31:0] e, v);
		total_checks++;
		if (e !== v)
		begin
			errors++;
			$display("[FAIL] %s exp %h got %h", s, e, v);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task tick;
		@(posedge bus_clock_2x);
		#1;
		n++;
		seen |= lock_n_oe === 1'b1;
		ads_cnt += !addr_strobe_n;
		data_cnt += wdata_take + rdata_valid_q;
	endtask
	// kind, size and word address in one vector
	task run(input [34:0] r);
		{req_write, req_rmw, req_inta, req_size, req_word_addr} = r;
		req_valid = 1;
		seen = 0;
		n = 0;
		ads_cnt = 0;
		data_cnt = 0;
		while (req_ready !== 1'b1 && n < 99)
			tick;
		tick;
		req_valid = 0;
		while (done_q !== 1'b1 && n < 99)
			tick;
		chk("done", 1, done_q);
		if (done_q !== 1'b1)
			close_out;
		repeat (2) tick;
	endtask
	initial
	begin
		{req_write, req_rmw, req_inta, req_size, req_word_addr, slow} = 0;
		repeat (10) tick;
		reset_n = 1;
		tick;
		slow = 1;
		run({3'h0, 2'h3, 30'h0ABCDE0});
		chk("addr", {30'h0ABCDE0, 2'h3}, lat);
		chk("rdata", {30'h0ABCDE3, 2'h0}, rdata_q);
		chk("read strobes", 8, ads_cnt);
		chk("read words", 8, data_cnt);
		$display("burst read ended");
		slow = 0;
		for (int s = 0; s < 4; s++)
		begin
			req_wdata = ~req_wdata;
			run({3'h4, 2'(s), 30'(s)});
			chk("size", 32'(s * 5), lat);
			chk("wdata", req_wdata, last_w);
			chk("write strobes", 2 + 2 * s, ads_cnt);
			chk("write takes", s + 1, data_cnt);
		end
		$display("writes ended");
		lk = 1;
		req_wdata = ~req_wdata;
		fork
			run({3'h2, 32'h20});
			begin
				repeat (9) tick;
				chk("lock wait", 0, lock_n_oe);
				lk = 0;
			end
		join
		chk("rmw lock", 1, seen);
		chk("rmw data", req_wdata, last_w);
		run({3'h1, 32'hC});
		chk("ack lock", 1, seen);
		tick;
		seen = req_ready;
		tick;
		chk("half clock", 1, seen ^ req_ready);
		hold_phase = 1;
		repeat (4) tick;
		chk("hold", 3, {addr_latch_oe, req_ready, addr_strobe_n, xcvr_enable_n});
		$display("lock and hold ended");
		close_out;
	end
endmodule // testbench
